// ---- common/flash_seq_pkg.sv ----
// Shared constants and types for the erase/suspend sequencer.
// Assumes a 100 MHz core clock and a 24-bit byte address.
package flash_seq_pkg;

   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OPC_SUSPEND      = 8'hb0;
   localparam logic [7:0] OPC_RESUME       = 8'h30;
   localparam logic [7:0] OPC_CLEAR_4K     = 8'h20;
   localparam logic [7:0] OPC_CLEAR_32K    = 8'h52;
   localparam logic [7:0] OPC_CLEAR_64K    = 8'hd8;

   // ----------------------------------------------------------------
   // Frame lengths in link clock edges
   // ----------------------------------------------------------------
   localparam logic [5:0] EDGES_1B_SINGLE = 6'h08;
   localparam logic [5:0] EDGES_1B_QUAD   = 6'h02;
   localparam logic [5:0] EDGES_4B_SINGLE = 6'h20;
   localparam logic [5:0] EDGES_4B_QUAD   = 6'h08;
   localparam logic [5:0] EDGES_SAT       = 6'h3f;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned PAGE_PROG_US     = 500;
   localparam int unsigned CLEAR_4K_US      = 40000;
   localparam int unsigned CLEAR_32K_US     = 200000;
   localparam int unsigned CLEAR_64K_US     = 300000;
   localparam int unsigned SUSPEND_LAT_US   = 28;
   localparam int unsigned PAGE_PROG_CYC    = PAGE_PROG_US * CLK_MHZ;
   localparam int unsigned CLEAR_4K_CYC     = CLEAR_4K_US * CLK_MHZ;
   localparam int unsigned CLEAR_32K_CYC    = CLEAR_32K_US * CLK_MHZ;
   localparam int unsigned CLEAR_64K_CYC    = CLEAR_64K_US * CLK_MHZ;
   localparam logic [11:0] SUSPEND_LAT_CYC  =
      12'(SUSPEND_LAT_US * CLK_MHZ);

   // ----------------------------------------------------------------
   // Region masks (upper address bits that name a region)
   // ----------------------------------------------------------------
   localparam logic [23:0] MASK_PAGE = 24'hffff00;
   localparam logic [23:0] MASK_4K   = 24'hfff000;
   localparam logic [23:0] MASK_32K  = 24'hff8000;
   localparam logic [23:0] MASK_64K  = 24'hff0000;
   localparam logic [6:0]  LAST_BLOCK = 7'h7f;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_PAGE, OP_4K, OP_32K, OP_64K
   } op_kind_t;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSP_WAIT} seq_state_t;

   // Capture of one frame on the link side
   typedef struct packed {
      logic [31:0] single_bits;
      logic [31:0] quad_bits;
      logic [5:0]  edges;
   } link_t;

   // Core state
   typedef struct packed {
      seq_state_t  state;
      logic        cs_meta;
      logic        cs_sync;
      logic        cs_prev;
      logic        write_in_progress_flag;
      logic        write_latch_flag;
      logic        erase_susp;
      logic        prog_susp;
      logic        chip_ok;
      logic        read_undef;
      logic        done;
      logic        prog_ack;
      op_kind_t    cur_kind;
      logic [23:0] cur_addr;
      logic [31:0] remain;
      op_kind_t    sus_kind;
      logic [23:0] sus_addr;
      logic [31:0] sus_remain;
      logic [11:0] lat;
   } core_t;

endpackage

// ---- core/flash_erase_suspend_sequencer.sv ----
// Erase, suspend and resume sequencing for a serial flash.
// Assumes the host link clock stops outside frames and that the
// four-lane mode level and program requests come from core logic.
//
// What this block does
// - While erase suspended, programs and reads elsewhere proceed normally.
// - Programs into a suspended erase region are ignored.
// - Reads of a suspended region are flagged as undefined data.
// - Program suspended: other erases run, erases over its page ignored.
// - Suspending an erase raises the erase-suspended flag.
// - Suspending a program raises the program-suspended flag.
// - Resume restarts the suspended operation and clears its flag.
// - Split run time never exceeds the uninterrupted cycle time.
// - Busy and suspend flags are presented for the status reads.
// - Opcode 20h clears the addressed 4KB sector to all ones.
// - Opcode 52h clears the addressed 32KB half block.
// - Opcode D8h clears the addressed 64KB block.
// - Erases need the write latch set by a prior enable.
// - Erase runs only if select rises right after the last bit.
// - Select rise on valid erase starts timed cycle with busy set.
// - Write latch is cleared before each timed cycle ends.
// - Erases aimed at protected or boot-locked regions are ignored.
// - Only one suspension at once; suspend during chip erase ignored.
// - Chip erase is refused while anything is suspended.
`timescale 1ns/1ns
`default_nettype none

module flash_erase_suspend_sequencer
   import flash_seq_pkg::*;
#(
   parameter logic [31:0] PAGE_CYCLES = 32'(flash_seq_pkg::PAGE_PROG_CYC),
   parameter logic [31:0] C4K_CYCLES  = 32'(flash_seq_pkg::CLEAR_4K_CYC),
   parameter logic [31:0] C32K_CYCLES = 32'(flash_seq_pkg::CLEAR_32K_CYC),
   parameter logic [31:0] C64K_CYCLES = 32'(flash_seq_pkg::CLEAR_64K_CYC)
)
(
   // Core clock and reset
   input  wire logic                      clock_in,
   input  wire logic                      srst_in,
   // Host link pins
   input  wire logic                      sclk_in,
   input  wire logic                      cs_n_in,
   input  wire logic [3:0]                dq_in,
   // Configuration from neighbouring core logic
   input  wire logic                      four_lane_command_mode_in,
   input  wire logic [3:0]                region_protect_bits_in,
   input  wire logic                      boot_lock_in,
   input  wire logic                      chip_erase_busy_in,
   // Program and read requests from neighbouring core logic
   input  wire logic                      prog_req_in,
   input  wire logic [23:0]               prog_addr_in,
   input  wire logic [23:0]               read_addr_in,
   // Status flags
   output logic                           write_in_progress_flag_out,
   output logic                           write_latch_flag_out,
   output logic                           erase_suspended_flag_out,
   output logic                           program_suspended_flag_out,
   output logic                           chip_erase_allowed_out,
   output logic                           read_undefined_out,
   // Array operation results
   output logic                           prog_accepted_out,
   output logic                           array_done_out,
   output flash_seq_pkg::op_kind_t        array_kind_out,
   output logic [23:0]                    array_addr_out
);
   import flash_seq_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [23:0] kind_mask(input op_kind_t k);
      case (k)
         OP_PAGE: kind_mask = MASK_PAGE;
         OP_4K:   kind_mask = MASK_4K;
         OP_32K:  kind_mask = MASK_32K;
         default: kind_mask = MASK_64K;
      endcase
   endfunction

   // Two regions overlap when equal on the coarser region's bits
   function automatic logic overlap(input logic [23:0] a,
                                    input op_kind_t    ka,
                                    input logic [23:0] b,
                                    input op_kind_t    kb);
      logic [23:0] m;
      m = kind_mask(ka) & kind_mask(kb);
      overlap = (a & m) == (b & m);
   endfunction

   // Protected span grows from the top block downward
   function automatic logic is_protected(input logic [23:0] a,
                                         input logic [3:0]  bp,
                                         input logic        boot);
      logic [7:0] span;
      span = (bp >= 4'h8) ? 8'h80 : 8'(8'h01 << bp) >> 1;
      is_protected = (boot && (a[22:16] == 7'h00))
         || ((bp != 4'h0) && ({1'b0, a[22:16]} >= (8'h80 - span)));
   endfunction

   function automatic op_kind_t clear_kind(input logic [7:0] opc);
      case (opc)
         OPC_CLEAR_4K:  clear_kind = OP_4K;
         OPC_CLEAR_32K: clear_kind = OP_32K;
         OPC_CLEAR_64K: clear_kind = OP_64K;
         default:       clear_kind = OP_NONE;
      endcase
   endfunction

   function automatic logic [31:0] kind_cycles(input op_kind_t k);
      case (k)
         OP_PAGE: kind_cycles = PAGE_CYCLES;
         OP_4K:   kind_cycles = C4K_CYCLES;
         OP_32K:  kind_cycles = C32K_CYCLES;
         default: kind_cycles = C64K_CYCLES;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Link domain: shift in every edge for both lane widths
   // ----------------------------------------------------------------
   link_t link;
   link_t next_link;
   logic  link_fresh;

   // Capture both widths so no mode level has to cross into sclk;
   // the first edge of a frame restarts words and count
   always_comb
   begin
      next_link = link;
      if (link_fresh)
      begin
         next_link.single_bits = {31'h0, dq_in[0]};
         next_link.quad_bits   = {28'h0, dq_in};
         next_link.edges       = 6'h01;
      end
      else
      begin
         next_link.single_bits = {link.single_bits[30:0], dq_in[0]};
         next_link.quad_bits   = {link.quad_bits[27:0], dq_in};
         next_link.edges       = (link.edges == EDGES_SAT) ? EDGES_SAT
                                 : link.edges + 6'h01;
      end
   end

   // Deselect only arms a fresh frame, so the captured words survive
   // the select rise and the core can read them while sclk is still
   always_ff @(posedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
         link_fresh <= 1'b1;
      else
         link_fresh <= 1'b0;
   end

   // Frame capture; restarted by the fresh flag, not by a reset
   always_ff @(posedge sclk_in)
   begin
      link <= next_link;
   end

   // ----------------------------------------------------------------
   // Core domain
   // ----------------------------------------------------------------
   core_t s;
   core_t next_s;

   logic        frame_end;
   logic        quad;
   logic [31:0] word;
   logic        one_byte;
   logic        four_byte;
   logic [7:0]  opc1;
   op_kind_t    ck;
   logic [23:0] faddr;
   logic        any_susp;

   // Frame decode; link words are static once select has risen
   always_comb
   begin
      frame_end = s.cs_sync && !s.cs_prev;
      quad      = four_lane_command_mode_in;
      word      = quad ? link.quad_bits : link.single_bits;
      one_byte  = link.edges == (quad ? EDGES_1B_QUAD : EDGES_1B_SINGLE);
      four_byte = link.edges == (quad ? EDGES_4B_QUAD : EDGES_4B_SINGLE);
      opc1      = word[7:0];
      ck        = four_byte ? clear_kind(word[31:24]) : OP_NONE;
      faddr     = word[23:0];
      any_susp  = s.erase_susp || s.prog_susp;
   end

   // Sequencer next state
   always_comb
   begin
      next_s          = s;
      next_s.cs_meta  = cs_n_in;
      next_s.cs_sync  = s.cs_meta;
      next_s.cs_prev  = s.cs_sync;
      next_s.done     = 1'b0;
      next_s.prog_ack = 1'b0;
      if (frame_end && one_byte && (opc1 == OPC_WRITE_ENABLE)
          && (s.state == ST_IDLE))
         next_s.write_latch_flag = 1'b1;
      case (s.state)
         ST_IDLE:
         begin
            if (frame_end && one_byte && (opc1 == OPC_RESUME) && any_susp)
            begin
               // Saved count continues, so total time is unchanged
               next_s.state      = ST_RUN;
               next_s.cur_kind   = s.sus_kind;
               next_s.cur_addr   = s.sus_addr;
               next_s.remain     = s.sus_remain;
               next_s.write_in_progress_flag        = 1'b1;
               next_s.erase_susp = 1'b0;
               next_s.prog_susp  = 1'b0;
            end
            else if (frame_end && (ck != OP_NONE) && s.write_latch_flag
                     && !s.erase_susp
                     && !is_protected(faddr, region_protect_bits_in,
                                      boot_lock_in)
                     && !(s.prog_susp && overlap(faddr, ck, s.sus_addr,
                                                 s.sus_kind)))
            begin
               next_s.state    = ST_RUN;
               next_s.cur_kind = ck;
               next_s.cur_addr = faddr & kind_mask(ck);
               next_s.remain   = kind_cycles(ck);
               next_s.write_in_progress_flag      = 1'b1;
               next_s.write_latch_flag      = 1'b0;
            end
            else if (prog_req_in && s.write_latch_flag && !s.prog_susp
                     && !(s.erase_susp && overlap(prog_addr_in, OP_PAGE,
                                                  s.sus_addr,
                                                  s.sus_kind)))
            begin
               next_s.state    = ST_RUN;
               next_s.cur_kind = OP_PAGE;
               next_s.cur_addr = prog_addr_in;
               next_s.remain   = PAGE_CYCLES;
               next_s.write_in_progress_flag      = 1'b1;
               next_s.write_latch_flag      = 1'b0;
               next_s.prog_ack = 1'b1;
            end
            // Suspend here finds nothing running and is dropped
            // Resume with nothing saved is dropped as well
         end
         ST_RUN:
         begin
            next_s.remain = s.remain - 32'h1;
            if (s.remain <= 32'h1)
            begin
               // Completion wins over a suspend arriving together
               next_s.state     = ST_IDLE;
               next_s.write_in_progress_flag       = 1'b0;
               next_s.done      = 1'b1;
               next_s.remain    = '0;
            end
            else if (frame_end && one_byte && (opc1 == OPC_SUSPEND)
                     && !any_susp && !chip_erase_busy_in)
            begin
               next_s.state      = ST_SUSP_WAIT;
               next_s.sus_kind   = s.cur_kind;
               next_s.sus_addr   = s.cur_addr;
               next_s.sus_remain = s.remain - 32'h1;
               next_s.lat        = SUSPEND_LAT_CYC;
               next_s.erase_susp = s.cur_kind != OP_PAGE;
               next_s.prog_susp  = s.cur_kind == OP_PAGE;
            end
         end
         ST_SUSP_WAIT:
         begin
            // Busy stays up until the array is parked
            next_s.lat = s.lat - 12'h001;
            if (s.lat <= 12'h001)
            begin
               next_s.state = ST_IDLE;
               next_s.write_in_progress_flag   = 1'b0;
            end
         end
         default:
            next_s.state = ST_IDLE;
      endcase
      next_s.chip_ok    = !(next_s.erase_susp || next_s.prog_susp);
      next_s.read_undef = (next_s.erase_susp || next_s.prog_susp)
         && overlap(read_addr_in, OP_PAGE, next_s.sus_addr,
                    next_s.sus_kind);
   end

   // Core register
   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         s         <= '0;
         s.state   <= ST_IDLE;
         s.cs_meta <= 1'b1;
         s.cs_sync <= 1'b1;
         s.cs_prev <= 1'b1;
         s.chip_ok <= 1'b1;
      end
      else
         s <= next_s;
   end

   // Flags for the status read paths
   always_comb
   begin
      write_in_progress_flag_out = s.write_in_progress_flag;
      write_latch_flag_out       = s.write_latch_flag;
      erase_suspended_flag_out   = s.erase_susp;
      program_suspended_flag_out = s.prog_susp;
      chip_erase_allowed_out     = s.chip_ok;
      read_undefined_out         = s.read_undef;
      prog_accepted_out          = s.prog_ack;
      array_done_out             = s.done;
      array_kind_out             = s.cur_kind;
      array_addr_out             = s.cur_addr;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Every check runs on the core clock and rests during reset
   default clocking core_cb @(posedge clock_in);
   endclocking
   default disable iff (srst_in);

   sequence cycle_start_s;
      $rose(s.write_in_progress_flag) && !$fell(s.erase_susp) && !$fell(s.prog_susp);
   endsequence

   sequence park_s;
      $rose(s.erase_susp || s.prog_susp);
   endsequence

   // Parked cycles with busy up; counted, as the latency is far too
   // long to unroll as a delay range
   logic [11:0] park_busy;
   always_ff @(posedge clock_in)
   begin
      if (srst_in || !(s.write_in_progress_flag && (s.state == ST_SUSP_WAIT)))
         park_busy <= 12'h000;
      else
         park_busy <= park_busy + 12'h001;
   end

   latch_needed_a: assert property (
      cycle_start_s |-> $past(s.write_latch_flag))
      else $error("cycle started without write latch");
   latch_cleared_a: assert property (
      cycle_start_s |-> !s.write_latch_flag)
      else $error("write latch still set in cycle");
   protect_honoured_a: assert property (
      cycle_start_s and (s.cur_kind != OP_PAGE) |->
         !is_protected(s.cur_addr, $past(region_protect_bits_in),
                       $past(boot_lock_in)))
      else $error("protected region erased");
   erase_flag_a: assert property (
      $rose(s.erase_susp) |-> $past(s.state == ST_RUN)
         && (s.sus_kind != OP_PAGE) && s.write_in_progress_flag)
      else $error("erase suspend flag wrong");
   prog_flag_a: assert property (
      $rose(s.prog_susp) |-> $past(s.cur_kind == OP_PAGE) && s.write_in_progress_flag)
      else $error("program suspend flag wrong");
   park_busy_a: assert property (
      park_s |-> s.write_in_progress_flag [*8])
      else $error("busy dropped right after suspend");
   park_bound_a: assert property (
      park_busy <= SUSPEND_LAT_CYC)
      else $error("suspend latency too long");
   park_release_a: assert property (
      ($fell(s.write_in_progress_flag) && $past(s.state == ST_SUSP_WAIT))
         |-> (park_busy == SUSPEND_LAT_CYC))
      else $error("suspend latency wrong");
   resume_run_a: assert property (
      $fell(s.erase_susp || s.prog_susp) |->
         s.write_in_progress_flag && (s.state == ST_RUN) && (s.remain == $past(s.sus_remain)))
      else $error("resume did not restart cycle");
   single_park_a: assert property (
      !(s.erase_susp && s.prog_susp))
      else $error("two operations suspended");
   chip_refused_a: assert property (
      park_s |-> !chip_erase_allowed_out)
      else $error("chip erase allowed while suspended");
   done_clears_a: assert property (
      s.done |-> !s.write_in_progress_flag && $past(s.write_in_progress_flag, 1) && (s.state == ST_IDLE))
      else $error("busy not cleared at completion");

endmodule // flash_erase_suspend_sequencer

`default_nettype wire

// ---- verification/host_link_model.sv ----
// Host side of the serial link: shifts one frame per call.
// Assumes the caller keeps frames apart; link clock idles low.
`timescale 1ns/1ns
`default_nettype none

module host_link_model
(
   // Link pins towards the device
   output logic       sclk_out,
   output logic       cs_n_out,
   output logic [3:0] dq_out
);
   // Idle link: select high, clock still; one early select rise
   // arms the device's frame start before the first frame
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b0;
      dq_out   = 4'h0;
      #1 cs_n_out = 1'b1;
   end

   // ----------------------------------------------------------------
   // One frame, MSB or upper nibble first, n clock edges long
   // ----------------------------------------------------------------
   task automatic frame(input logic [31:0] w, input int n,
                        input logic quad);
      cs_n_out = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         #4 dq_out = quad ? w[31:28] : {~dq_out[3:1], w[31]};
         w = quad ? w << 4 : w << 1;
         #4 sclk_out = 1'b1;
         #7 sclk_out = 1'b0;
      end
      #4 cs_n_out = 1'b1;
      // Released lanes flip so no stale value passes for data
      dq_out = ~dq_out;
   endtask
endmodule // host_link_model
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the erase/suspend sequencer.
// Assumes short timed-cycle parameters; suspend latency is fixed.
`timescale 1ns/1ns
`default_nettype none

module testbench;
   import flash_seq_pkg::*;
   localparam int P = 300, A = 400, B = 500, C = 600;
   logic clock_in = 1'b0, srst_in = 1'b1, quad = 1'b0, boot = 1'b0;
   logic ceb = 1'b0, preq = 1'b0;
   logic [3:0] rp = 4'h0;
   logic [23:0] pa = 24'h0, rda = 24'h0;
   wire logic sclk_in, cs_n_in;
   wire logic [3:0] dq_in;
   logic write_in_progress_flag, write_latch_flag, es, ps, ce_ok, rdu, pacc, done;
   op_kind_t kind;
   logic [23:0] aaddr;
   int bad_count = 0, tests_run = 0, n;

   // Core clock
   always #5 clock_in = ~clock_in;

   host_link_model h (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
                      .dq_out(dq_in));

   flash_erase_suspend_sequencer #(.PAGE_CYCLES(32'(P)),
      .C4K_CYCLES(32'(A)), .C32K_CYCLES(32'(B)), .C64K_CYCLES(32'(C)))
   dut (.clock_in, .srst_in, .sclk_in, .cs_n_in, .dq_in,
      .four_lane_command_mode_in(quad), .region_protect_bits_in(rp),
      .boot_lock_in(boot), .chip_erase_busy_in(ceb),
      .prog_req_in(preq), .prog_addr_in(pa), .read_addr_in(rda),
      .write_in_progress_flag_out(write_in_progress_flag), .write_latch_flag_out(write_latch_flag),
      .erase_suspended_flag_out(es), .program_suspended_flag_out(ps),
      .chip_erase_allowed_out(ce_ok), .read_undefined_out(rdu),
      .prog_accepted_out(pacc), .array_done_out(done),
      .array_kind_out(kind), .array_addr_out(aaddr));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic summarize();
      $display("errors %0d checks %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Frame then settle; host waits out the detect latency
   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                      input bit ad);
      // Let a lane mode set at this edge settle before framing
      #1;
      h.frame({op, ad ? a : 24'h0}, ad ? (quad ? 8 : 32)
              : (quad ? 2 : 8), quad);
      repeat (6) @(posedge clock_in);
      #1;
   endtask

   // Bounded poll of busy, as the host would do
   task automatic wait_idle();
      n = 0;
      do
      begin
         @(posedge clock_in);
         #1 n++;
      end
      while (write_in_progress_flag !== 1'b0 && n < 5000);
      chk(write_in_progress_flag, 0);
   endtask

   task automatic prog(input logic [23:0] a, input logic e);
      @(posedge clock_in);
      preq <= 1'b1;
      pa   <= a;
      @(posedge clock_in);
      preq <= 1'b0;
      #1 chk(pacc, e);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Per-size erase table, index 0 in the lowest slot
   logic [2:0][7:0]  ops = {8'hd8, 8'h52, 8'h20};
   logic [2:0][23:0] ads = {24'h03abcd, 24'h01ffff, 24'h012345};
   logic [2:0][23:0] bas = {24'h030000, 24'h018000, 24'h012000};
   logic [2:0][2:0]  kds = {OP_64K, OP_32K, OP_4K};
   logic [2:0][15:0] cyc = {C[15:0], B[15:0], A[15:0]};

   initial
   begin
      repeat (20) @(posedge clock_in);
      srst_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1 chk(ce_ok, 1);
      cmd(8'h20, 24'h001000, 1); chk(write_in_progress_flag, 0);
      cmd(8'h06, 0, 0); chk(write_latch_flag, 1);
      h.frame({8'h20, 24'h001000}, 31, 0);
      repeat (6) @(posedge clock_in);
      cmd(8'h30, 0, 0); chk(write_in_progress_flag, 0);
      @(posedge clock_in);
      rp <= 4'h1;
      boot <= 1'b1;
      cmd(8'h20, 24'h7f1000, 1); chk(write_in_progress_flag, 0);
      cmd(8'hd8, 24'h00f000, 1); chk(write_in_progress_flag, 0);
      @(posedge clock_in);
      rp <= 4'h0;
      boot <= 1'b0;
      // Each erase size, lane mode alternating
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clock_in);
         quad <= i[0];
         cmd(8'h06, 0, 0);
         cmd(ops[i], ads[i], 1); chk(write_in_progress_flag, 1);
         chk(write_latch_flag, 0);
         wait_idle(); chk(done, 1);
         chk(aaddr, bas[i]);
         chk(kind, kds[i]);
         chk(n > cyc[i] - 12 && n <= cyc[i], 1);
      end
      // Erase suspend in four-lane mode, then resume
      @(posedge clock_in);
      quad <= 1'b1;
      cmd(8'h06, 0, 0);
      cmd(8'hd8, 24'h020000, 1);
      repeat (200) @(posedge clock_in);
      cmd(8'hb0, 0, 0); chk(es, 1);
      chk(ce_ok, 0);
      chk(write_in_progress_flag, 1);
      wait_idle(); chk(n <= 2800, 1);
      cmd(8'hb0, 0, 0); chk({es, ps}, 2);
      @(posedge clock_in);
      rda <= 24'h02f100;
      repeat (3) @(posedge clock_in);
      #1 chk(rdu, 1);
      rda <= 24'h300000;
      repeat (3) @(posedge clock_in);
      #1 chk(rdu, 0);
      cmd(8'h06, 0, 0);
      prog(24'h020100, 0);
      prog(24'h300000, 1);
      cmd(8'hb0, 0, 0); chk(ps, 0);
      wait_idle();
      cmd(8'h30, 0, 0); chk({es, write_in_progress_flag}, 1);
      chk(ce_ok, 1);
      wait_idle(); chk(aaddr, 24'h020000);
      chk(n <= C - 200, 1);
      repeat (20000) @(posedge clock_in);
      // Program suspend on a single lane
      quad <= 1'b0;
      cmd(8'h06, 0, 0);
      prog(24'h400000, 1);
      repeat (50) @(posedge clock_in);
      cmd(8'hb0, 0, 0); chk(ps, 1);
      wait_idle();
      cmd(8'h06, 0, 0);
      cmd(8'h20, 24'h400800, 1); chk(write_in_progress_flag, 0);
      cmd(8'h20, 24'h500000, 1); chk(write_in_progress_flag, 1);
      wait_idle();
      cmd(8'h30, 0, 0); chk({ps, write_in_progress_flag}, 1);
      wait_idle(); chk(kind, OP_PAGE);
      repeat (20000) @(posedge clock_in);
      // Suspend and resume with nothing to act on, then suspend during chip erase busy
      cmd(8'hb0, 0, 0); chk({es, ps, write_in_progress_flag}, 0);
      cmd(8'h30, 0, 0); chk({es, ps, write_in_progress_flag}, 0);
      cmd(8'h06, 0, 0);
      cmd(8'h20, 24'h600000, 1);
      ceb <= 1'b1;
      cmd(8'hb0, 0, 0); chk(es, 0);
      ceb <= 1'b0;
      wait_idle(); chk(done, 1);
      summarize();
   end

   // Hang guard, well past the expected run length
   initial
   begin
      repeat (90000) @(posedge clock_in);
      bad_count++;
      summarize();
   end
endmodule // testbench
`default_nettype wire
